// ### design/sdram_ctl.sv
`timescale 1ns/1ps
module sdram_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // fill level
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] slot [DEPTH];
   logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
   logic [AW:0] count_reg;
   logic push, pop;
   // honest full and empty
   assign in_ready = count_reg != (AW+1)'(DEPTH);
   assign out_valid = count_reg != '0;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = slot[rd_ptr_reg];
   assign level = count_reg;
   // storage
   always_ff @(posedge clk) begin
      if (push) begin
         slot[wr_ptr_reg] <= in_data;
      end
   end
   // pointers and count
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule : sdram_fifo

module sdram_ctl #(
   parameter int INIT_WAIT = sdram_pkg::INIT_CYC,
   parameter int FIFO_DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // link to memory
   sdram_if.ctl link,
   // access requests
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [sdram_pkg::BA_W-1:0] req_bank,
   input wire logic [sdram_pkg::ROW_W-1:0] req_row,
   input wire logic [sdram_pkg::COL_W-1:0] req_col,
   input wire logic [sdram_pkg::DQ_W-1:0] req_wdata,
   // read data
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [sdram_pkg::DQ_W-1:0] rd_data,
   // status
   output logic init_done
);
   import sdram_pkg::*;
   localparam int LW = $clog2(FIFO_DEPTH) + 1;
   typedef enum logic [4:0] {
      ST_INIT = 5'h01,
      ST_PALL = 5'h02,
      ST_MODE = 5'h04,
      ST_IDLE = 5'h08,
      ST_TURN = 5'h10
   } ctl_state_t;
   ctl_state_t state_reg, state_next;
   logic [11:0] init_cnt_reg;
   logic [1:0] turn_cnt_reg;
   logic [3:0] rc_cnt [BANKS];
   logic [3:0] rp_cnt [BANKS];
   logic [3:0] rcd_cnt [BANKS];
   logic [3:0] rrd_cnt_reg, gap_cnt_reg;
   logic [CAP_W-1:0] cap_reg;
   logic [LW-1:0] resv_reg, level;
   logic last_rd_reg;
   logic [BANKS-1:0] open_reg;
   logic [ROW_W-1:0] row_reg [BANKS];
   logic [3:0] cmd_reg, nxt_cmd;
   logic [BA_W-1:0] ba_reg, nxt_ba;
   logic [ROW_W-1:0] addr_reg, nxt_addr;
   logic [DQM_W-1:0] dqm_reg, nxt_dqm;
   logic [DQ_W-1:0] dq_o_reg;
   logic oe_n_reg, accept, go_turn, hit, rd_room, fifo_ready, rp_idle;
   // the mode word: burst of four, sequential, chosen latency, single writes
   localparam logic [ROW_W-1:0] MODE_WORD = ROW_W'((1 << WSL_BIT) | (CAS_LAT << CL_LSB) | (BL_FOUR << BL_LSB)); // [RULE1] [RULE2]
   // next command decision
   always_comb begin
      nxt_cmd = CMD_NOP;
      nxt_ba = req_bank;
      nxt_addr = '0;
      nxt_dqm = '0;
      accept = 1'b0;
      go_turn = 1'b0;
      state_next = state_reg;
      hit = open_reg[req_bank] && row_reg[req_bank] == req_row; // [RULE22]
      rd_room = fifo_ready && (32'(level) + 32'(resv_reg) + CTL_BL) <= FIFO_DEPTH;
      rp_idle = 1'b1;
      for (int b = 0; b < BANKS; b++) begin
         rp_idle = rp_idle && rp_cnt[b] == 4'h0;
      end
      case (state_reg)
         ST_INIT: begin
            nxt_dqm = '1;
            if (init_cnt_reg == 12'h000) begin
               state_next = ST_PALL;
            end
         end
         ST_PALL: begin
            nxt_dqm = '1;
            nxt_cmd = CMD_PRE;
            nxt_addr[AP_BIT] = 1'b1;
            state_next = ST_MODE;
         end
         ST_MODE: begin
            nxt_dqm = '1;
            if (rp_idle) begin
               nxt_cmd = CMD_LMR; // [RULE18]
               nxt_addr = MODE_WORD;
               state_next = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (req_valid && init_cnt_reg == 12'h000) begin
               if (hit) begin
                  if (rcd_cnt[req_bank] == 4'h0) begin // [RULE4]
                     if (req_write) begin
                        if (!last_rd_reg) begin
                           nxt_cmd = CMD_WR;
                           nxt_addr = ROW_W'(req_col);
                           accept = 1'b1;
                        end else if (cap_reg == '0) begin
                           go_turn = 1'b1; // [RULE13]
                           nxt_dqm = '1;
                           state_next = ST_TURN;
                        end
                     end else if (gap_cnt_reg == 4'h0 && rd_room) begin // [RULE11] [RULE12]
                        nxt_cmd = CMD_RD;
                        nxt_addr = ROW_W'(req_col);
                        accept = 1'b1;
                     end
                  end
               end else if (open_reg[req_bank]) begin
                  if (gap_cnt_reg == 4'h0) begin
                     nxt_cmd = CMD_PRE; // [RULE5] [RULE17]
                  end
               end else if (rc_cnt[req_bank] == 4'h0 && rp_cnt[req_bank] == 4'h0 && rrd_cnt_reg == 4'h0) begin
                  nxt_cmd = CMD_ACT; // [RULE3] [RULE5] [RULE6] [RULE18]
                  nxt_addr = req_row;
               end
            end
         end
         ST_TURN: begin
            nxt_dqm = '1; // [RULE14]
            if (turn_cnt_reg == 2'h0) begin
               nxt_dqm = '0; // [RULE16]
               nxt_cmd = CMD_WR;
               nxt_addr = ROW_W'(req_col);
               accept = 1'b1;
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_INIT;
      endcase
   end
   assign req_ready = accept;
   assign init_done = state_reg == ST_IDLE && init_cnt_reg == 12'h000;
   // sequencing and registered link outputs
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_INIT;
         init_cnt_reg <= 12'(INIT_WAIT);
         turn_cnt_reg <= '0;
         cmd_reg <= CMD_NOP;
         ba_reg <= '0;
         addr_reg <= '0;
         dqm_reg <= '1;
         dq_o_reg <= '0;
         oe_n_reg <= 1'b1;
         last_rd_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (nxt_cmd == CMD_LMR) begin
            init_cnt_reg <= 12'h001;
         end else if (init_cnt_reg != 12'h000) begin
            init_cnt_reg <= init_cnt_reg - 12'h001;
         end
         if (go_turn) begin
            turn_cnt_reg <= 2'(DQM_LEAD);
         end else if (turn_cnt_reg != 2'h0) begin
            turn_cnt_reg <= turn_cnt_reg - 2'h1;
         end
         cmd_reg <= nxt_cmd;
         ba_reg <= nxt_ba;
         addr_reg <= nxt_addr;
         dqm_reg <= nxt_dqm;
         dq_o_reg <= req_wdata;
         oe_n_reg <= nxt_cmd != CMD_WR;
         if (nxt_cmd == CMD_RD) begin
            last_rd_reg <= 1'b1;
         end else if (nxt_cmd == CMD_WR) begin
            last_rd_reg <= 1'b0;
         end
      end
   end
   // per-bank spacing timers
   generate
      for (genvar b = 0; b < BANKS; b++) begin : g_bank
         logic act_b, pre_b;
         assign act_b = nxt_cmd == CMD_ACT && nxt_ba == b;
         assign pre_b = nxt_cmd == CMD_PRE && (nxt_addr[AP_BIT] || nxt_ba == b);
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               rc_cnt[b] <= '0;
               rp_cnt[b] <= '0;
               rcd_cnt[b] <= '0;
            end else begin
               rc_cnt[b] <= act_b ? 4'(RC_CYC - 1) : (rc_cnt[b] != 4'h0 ? rc_cnt[b] - 4'h1 : 4'h0); // [RULE5]
               rp_cnt[b] <= pre_b ? 4'(RP_CYC - 1) : (rp_cnt[b] != 4'h0 ? rp_cnt[b] - 4'h1 : 4'h0); // [RULE18]
               rcd_cnt[b] <= act_b ? 4'(RCD_CYC - 1) : (rcd_cnt[b] != 4'h0 ? rcd_cnt[b] - 4'h1 : 4'h0); // [RULE4]
            end
         end
      end
   endgenerate
   // bank table, cross-bank and read spacing, capture window, fifo credit
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         open_reg <= '0;
         for (int b = 0; b < BANKS; b++) begin
            row_reg[b] <= '0;
         end
         rrd_cnt_reg <= '0;
         gap_cnt_reg <= '0;
         cap_reg <= '0;
         resv_reg <= '0;
      end else begin
         if (nxt_cmd == CMD_ACT) begin
            open_reg[nxt_ba] <= 1'b1; // [RULE22]
            row_reg[nxt_ba] <= nxt_addr;
         end else if (nxt_cmd == CMD_PRE) begin
            if (nxt_addr[AP_BIT]) begin
               open_reg <= '0;
            end else begin
               open_reg[nxt_ba] <= 1'b0;
            end
         end
         rrd_cnt_reg <= (nxt_cmd == CMD_ACT) ? 4'(RRD_CYC - 1)
            : (rrd_cnt_reg != 4'h0 ? rrd_cnt_reg - 4'h1 : 4'h0); // [RULE6]
         gap_cnt_reg <= (nxt_cmd == CMD_RD) ? 4'(CTL_BL - 1)
            : (gap_cnt_reg != 4'h0 ? gap_cnt_reg - 4'h1 : 4'h0); // [RULE11]
         cap_reg <= (cap_reg >> 1) | ((nxt_cmd == CMD_RD) ? CAP_MASK : '0); // [RULE8]
         resv_reg <= resv_reg + ((nxt_cmd == CMD_RD) ? LW'(CTL_BL) : '0) - {{(LW-1){1'b0}}, cap_reg[0]};
      end
   end
   // read data buffer
   sdram_fifo #(.WIDTH(DQ_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
      .clk(clk),
      .nrst(nrst),
      .in_valid(cap_reg[0]),
      .in_ready(fifo_ready),
      .in_data(link.dq),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data),
      .level(level)
   );
   assign link.cmd = cmd_reg;
   assign link.ba = ba_reg;
   assign link.addr = addr_reg;
   assign link.dqm = dqm_reg;
   assign link.ctl_dq_o = dq_o_reg;
   assign link.ctl_dq_oe_n = oe_n_reg;
endmodule : sdram_ctl

// ### design/sdram_pkg.sv
// What this block does
// RULE1 - write single-location bit makes writes one word
// RULE2 - controller picks latency allowed by clock
// RULE3 - controller activates row before column commands
// RULE4 - controller waits activate-to-column cycles, rounded up
// RULE5 - precharge first; same-bank activates spaced apart
// RULE6 - activates to different banks spaced apart
// RULE7 - read auto-precharge flag closes row after burst
// RULE8 - first word after latency, then one per cycle
// RULE9 - data pins float once burst ends
// RULE10 - full-page read wraps and runs until stopped
// RULE11 - new read truncates or follows, gapless data
// RULE12 - read accepted any cycle after previous read
// RULE13 - controller leaves idle cycle before write turnaround
// RULE14 - mask raised three clocks ahead, two-clock output latency
// RULE15 - registered write floats pins if mask was high
// RULE16 - controller lowers mask in the write cycle itself, zero latency
// RULE17 - precharge ends read latency-minus-one before last
// RULE18 - nothing to bank until precharge recovery passes
// RULE19 - burst terminate ends read latency-minus-one before last
// RULE20 - pins driven from n+m-1, valid by n+m
// RULE21 - mode word field positions for burst and latency
// RULE22 - controller tracks open state and row per bank
package sdram_pkg;
   // geometry
   localparam int BANKS = 4;
   localparam int BA_W = 2;
   localparam int ROW_W = 12;
   localparam int COL_W = 8;
   localparam int DQ_W = 16;
   localparam int DQM_W = 2;
   // commands as {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_LMR = 4'h0;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam logic [3:0] CMD_RD = 4'h5;
   localparam logic [3:0] CMD_BST = 4'h6;
   localparam logic [3:0] CMD_NOP = 4'h7;
   // mode word layout
   localparam int BL_LSB = 0;
   localparam int BL_W = 3;
   localparam int BT_BIT = 3;
   localparam int CL_LSB = 4;
   localparam int CL_W = 3;
   localparam int OPM_LSB = 7;
   localparam int WSL_BIT = 9;
   localparam int AP_BIT = 10;
   localparam logic [2:0] BL_FULL = 3'h7;
   localparam logic [2:0] BL_FOUR = 3'h2;
   localparam logic [ROW_W-1:0] MODE_RST = 12'h000;
   // clock and latency choice
   localparam int CLK_NS = 40;
   localparam int CLK_MHZ = 25;
   localparam int CL2_MAX_MHZ = 100;
   localparam int CAS_LAT = (CLK_MHZ <= CL2_MAX_MHZ) ? 2 : 3;
   // timing in ns (init wait in us) and derived cycles (least times round up)
   localparam int T_RCD_NS = 20;
   localparam int T_RC_NS = 60;
   localparam int T_RP_NS = 20;
   localparam int T_RRD_NS = 20;
   localparam int T_INIT_US = 100;
   localparam int RCD_CYC = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
   localparam int RC_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
   localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
   localparam int RRD_CYC = (T_RRD_NS + CLK_NS - 1) / CLK_NS;
   localparam int INIT_CYC = (T_INIT_US * 1000 + CLK_NS - 1) / CLK_NS;
   // mask lead before a write, controller burst and capture window
   localparam int DQM_LEAD = 3;
   localparam int CTL_BL = 4;
   localparam int CAP_W = 12;
   localparam logic [CAP_W-1:0] CAP_MASK = CAP_W'(((1 << CTL_BL) - 1) << CAS_LAT);
endpackage : sdram_pkg

// ### design/sdram_if.sv
`timescale 1ns/1ps
interface sdram_if;
   logic [3:0] cmd;
   logic [sdram_pkg::BA_W-1:0] ba;
   logic [sdram_pkg::ROW_W-1:0] addr;
   logic [sdram_pkg::DQM_W-1:0] dqm;
   logic [sdram_pkg::DQ_W-1:0] ctl_dq_o;
   logic ctl_dq_oe_n;
   logic [sdram_pkg::DQ_W-1:0] mem_dq_o;
   logic mem_dq_oe_n;
   logic [sdram_pkg::DQ_W-1:0] dq;
   // shared data wire resolved from the enables, zero when nobody drives
   assign dq = !mem_dq_oe_n ? mem_dq_o : (!ctl_dq_oe_n ? ctl_dq_o : '0);
   modport ctl (output cmd, ba, addr, dqm, ctl_dq_o, ctl_dq_oe_n, input dq);
   modport mem (input cmd, ba, addr, dqm, dq, output mem_dq_o, mem_dq_oe_n);
endinterface : sdram_if

// ### design/sdram_mem.sv
`timescale 1ns/1ps
module sdram_mem #(
   parameter int ROW_KEEP = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // link to controller
   sdram_if.mem link,
   // status
   output logic [sdram_pkg::ROW_W-1:0] mode_word,
   output logic [sdram_pkg::BANKS-1:0] bank_open,
   output logic write_invalid
);
   import sdram_pkg::*;
   localparam int MA_W = BA_W + ROW_KEEP + COL_W;
   logic [DQ_W-1:0] store [2**MA_W];
   logic [ROW_W-1:0] mode_reg;
   logic [BANKS-1:0] open_reg;
   logic [ROW_W-1:0] row_reg [BANKS];
   logic act_reg, wr_reg, ap_reg, full_reg, dqm_hi_reg, oe_n_reg, bad_reg;
   logic [BA_W-1:0] bank_reg;
   logic [COL_W-1:0] start_reg, idx_reg, mask_reg;
   logic [1:0] pv_reg;
   logic [DQ_W-1:0] pd_reg [2];
   logic [DQ_W-1:0] dq_reg;
   logic is_rd, is_wr, wr_ok, wr_bad, pre_hit, is_bst, rd_more, wr_more, last, ap_close, cl3;
   logic new_full, new_ap;
   logic [COL_W-1:0] bl_mask, new_mask, cur_col, col;
   logic [BA_W-1:0] bank;
   logic [MA_W-1:0] maddr;
   // command decode and burst column generation
   always_comb begin
      is_rd = link.cmd == CMD_RD;
      is_wr = link.cmd == CMD_WR;
      is_bst = link.cmd == CMD_BST;
      pre_hit = link.cmd == CMD_PRE && (link.addr[AP_BIT] || link.ba == bank_reg);
      cl3 = mode_reg[CL_LSB +: CL_W] == 3'h3; // [RULE21]
      case (mode_reg[BL_LSB +: BL_W]) // [RULE21]
         3'h0: bl_mask = 8'h00;
         3'h1: bl_mask = 8'h01;
         3'h2: bl_mask = 8'h03;
         3'h3: bl_mask = 8'h07;
         default: bl_mask = 8'hFF;
      endcase
      // single-location writes when the bit is set
      new_mask = (is_wr && mode_reg[WSL_BIT]) ? 8'h00 : bl_mask; // [RULE1]
      new_full = !(is_wr && mode_reg[WSL_BIT]) && mode_reg[BL_LSB +: BL_W] == BL_FULL;
      new_ap = link.addr[AP_BIT];
      // sequential wraps within block; full page wraps the whole row
      cur_col = mode_reg[BT_BIT] ? (start_reg ^ idx_reg)
         : ((start_reg & ~mask_reg) | ((start_reg + idx_reg) & mask_reg)); // [RULE10]
      // a write over live read data needs the mask high one clock before
      wr_bad = is_wr && (|pv_reg || !oe_n_reg) && !dqm_hi_reg; // [RULE15]
      wr_ok = is_wr && !wr_bad;
      // a read, write, burst terminate or precharge of the burst bank stops the running burst
      rd_more = act_reg && !wr_reg && !is_rd && !is_wr && !pre_hit && !is_bst; // [RULE11] [RULE17] [RULE19]
      wr_more = act_reg && wr_reg && !is_rd && !is_wr && !pre_hit && !is_bst;
      last = !full_reg && idx_reg == mask_reg;
      ap_close = ((rd_more || wr_more) && last && ap_reg)
         || ((is_rd || wr_ok) && new_mask == 8'h00 && new_ap); // [RULE7]
      col = (is_rd || is_wr) ? link.addr[COL_W-1:0] : cur_col;
      bank = (is_rd || is_wr) ? link.ba : bank_reg;
      maddr = {bank, row_reg[bank][ROW_KEEP-1:0], col};
   end
   // mode word load
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mode_reg <= MODE_RST;
      end else if (link.cmd == CMD_LMR) begin
         mode_reg <= link.addr;
      end
   end
   // bank open table
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         open_reg <= '0;
         for (int b = 0; b < BANKS; b++) begin
            row_reg[b] <= '0;
         end
      end else begin
         if (ap_close) begin
            open_reg[bank] <= 1'b0; // [RULE7]
         end
         if (link.cmd == CMD_ACT) begin
            open_reg[link.ba] <= 1'b1;
            row_reg[link.ba] <= link.addr;
         end else if (link.cmd == CMD_PRE) begin
            if (link.addr[AP_BIT]) begin
               open_reg <= '0;
            end else begin
               open_reg[link.ba] <= 1'b0;
            end
         end
      end
   end
   // burst engine, restarted by any read on any cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         act_reg <= 1'b0;
         wr_reg <= 1'b0;
         ap_reg <= 1'b0;
         full_reg <= 1'b0;
         bank_reg <= '0;
         start_reg <= '0;
         idx_reg <= '0;
         mask_reg <= '0;
      end else if (is_rd || wr_ok) begin
         act_reg <= new_mask != 8'h00 || new_full; // [RULE12]
         wr_reg <= is_wr;
         ap_reg <= new_ap;
         full_reg <= new_full;
         bank_reg <= link.ba;
         start_reg <= link.addr[COL_W-1:0];
         idx_reg <= 8'h01;
         mask_reg <= new_mask;
      end else if (rd_more || wr_more) begin
         idx_reg <= idx_reg + 8'h01; // [RULE10]
         if (last) begin
            act_reg <= 1'b0;
         end
      end else if (pre_hit || is_bst || is_wr) begin
         act_reg <= 1'b0;
      end
   end
   // write data taken with zero mask latency
   always_ff @(posedge clk) begin
      if (wr_ok || wr_more) begin
         for (int l = 0; l < DQM_W; l++) begin
            if (!link.dqm[l]) begin
               store[maddr][l*8 +: 8] <= link.dq[l*8 +: 8];
            end
         end
      end
   end
   // output pipe, mask delay and pin drive
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pv_reg <= '0;
         pd_reg[0] <= '0;
         pd_reg[1] <= '0;
         dqm_hi_reg <= 1'b1;
         dq_reg <= '0;
         oe_n_reg <= 1'b1;
         bad_reg <= 1'b0;
      end else begin
         dqm_hi_reg <= &link.dqm; // [RULE14]
         pd_reg[0] <= store[maddr]; // [RULE8]
         pd_reg[1] <= pd_reg[0];
         pv_reg <= is_wr ? 2'h0 : {pv_reg[0], is_rd || rd_more}; // [RULE15]
         dq_reg <= cl3 ? pd_reg[1] : pd_reg[0]; // [RULE20]
         oe_n_reg <= is_wr || !((cl3 ? pv_reg[1] : pv_reg[0]) && !dqm_hi_reg); // [RULE9] [RULE14] [RULE20]
         bad_reg <= wr_bad;
      end
   end
   assign link.mem_dq_o = dq_reg;
   assign link.mem_dq_oe_n = oe_n_reg;
   assign mode_word = mode_reg;
   assign bank_open = open_reg;
   assign write_invalid = bad_reg;
endmodule : sdram_mem

// ### verif/sdram_link_sva.sv
`timescale 1ns/1ps
module sdram_link_sva (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // link signals
   input wire logic [3:0] cmd,
   input wire logic [sdram_pkg::BA_W-1:0] ba,
   input wire logic [sdram_pkg::ROW_W-1:0] addr,
   input wire logic [sdram_pkg::DQM_W-1:0] dqm,
   input wire logic ctl_dq_oe_n,
   input wire logic mem_dq_oe_n
);
   import sdram_pkg::*;
   logic [BANKS-1:0] open_reg;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // banks opened by activate, closed by precharge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         open_reg <= '0;
      end else if (cmd == CMD_ACT) begin
         open_reg[ba] <= 1'b1;
      end else if (cmd == CMD_PRE) begin
         if (addr[AP_BIT]) begin
            open_reg <= '0;
         end else begin
            open_reg[ba] <= 1'b0;
         end
      end
   end
   chk_rd_drive_start: assert property ((cmd == CMD_RD && dqm == 2'b00) |-> ##2 !mem_dq_oe_n)
      else $error("read data not driven after latency");
   chk_burst_words: assert property ((cmd == CMD_RD && dqm == 2'b00)
      ##1 (cmd == CMD_NOP && dqm == 2'b00)[*3] |-> (!mem_dq_oe_n)[*3])
      else $error("burst words missing");
   // two reads four cycles apart keep the pins driven with no gap
   chk_gapless_reads: assert property ((cmd == CMD_RD && dqm == 2'b00)
      ##1 (cmd == CMD_NOP && dqm == 2'b00)[*3] ##1 (cmd == CMD_RD && dqm == 2'b00) |-> (!mem_dq_oe_n)[*5])
      else $error("gap between consecutive bursts");
   chk_burst_float: assert property ((cmd == CMD_RD) ##1 (cmd == CMD_NOP)[*6] |-> mem_dq_oe_n)
      else $error("data pins not released after burst");
   chk_wr_float: assert property ((cmd == CMD_WR) |=> mem_dq_oe_n)
      else $error("memory drives after write");
   chk_mask_suppress: assert property ((dqm == 2'b11) |-> ##2 mem_dq_oe_n)
      else $error("mask did not stop output");
   chk_no_contention: assert property (!(!mem_dq_oe_n && !ctl_dq_oe_n))
      else $error("both ends drive data");
   chk_wr_unmasked: assert property ((cmd == CMD_WR) |-> (dqm == 2'b00))
      else $error("write data masked");
   chk_lmr_latency: assert property ((cmd == CMD_LMR) |-> (addr[CL_LSB +: CL_W] == CL_W'(CAS_LAT)))
      else $error("wrong latency in mode word");
   chk_act_spacing: assert property ((cmd == CMD_ACT) ##1 (cmd == CMD_ACT) |-> (ba != $past(ba)))
      else $error("same bank activates too close");
   chk_col_open: assert property ((cmd == CMD_RD || cmd == CMD_WR) |-> open_reg[ba])
      else $error("column command to idle bank");
   cover property ((cmd == CMD_RD) ##[1:4] (cmd == CMD_RD));
   cover property ((dqm == 2'b11) ##1 (cmd == CMD_WR));
   cover property ((cmd == CMD_PRE) ##[1:3] (cmd == CMD_ACT));
endmodule : sdram_link_sva

// ### verif/sdram_activate_read_path_tb.sv
`timescale 1ns/1ps
module sdram_activate_read_path_tb;
   import sdram_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic [BA_W-1:0] req_bank = '0;
   logic [ROW_W-1:0] req_row = '0;
   logic [COL_W-1:0] req_col = '0;
   logic [DQ_W-1:0] req_wdata = '0;
   logic rd_ready = 1'b0;
   logic req_ready, rd_valid, init_done, write_invalid;
   logic [DQ_W-1:0] rd_data;
   logic [ROW_W-1:0] mode_word;
   logic [BANKS-1:0] bank_open;
   logic [DQ_W-1:0] exp_mem [int];
   logic [DQ_W-1:0] exp_q [$];
   logic inv_seen = 1'b0;
   int failures = 0;
   int n_compared = 0;
   sdram_if link ();
   sdram_ctl #(.INIT_WAIT(5), .FIFO_DEPTH(8)) u_sdram_ctl (.clk(clk), .nrst(nrst), .link(link.ctl),
      .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_bank(req_bank),
      .req_row(req_row), .req_col(req_col), .req_wdata(req_wdata), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .rd_data(rd_data), .init_done(init_done));
   sdram_mem u_sdram_mem (.clk(clk), .nrst(nrst), .link(link.mem), .mode_word(mode_word),
      .bank_open(bank_open), .write_invalid(write_invalid));
   sdram_link_sva u_sdram_link_sva (.clk(clk), .nrst(nrst), .cmd(link.cmd), .ba(link.ba), .addr(link.addr),
      .dqm(link.dqm), .ctl_dq_oe_n(link.ctl_dq_oe_n), .mem_dq_oe_n(link.mem_dq_oe_n));
   // clock and refused write monitor
   always #20 clk = ~clk;
   always @(posedge clk) if (write_invalid === 1'b1) inv_seen <= 1'b1;
   task automatic check16(input logic [DQ_W-1:0] got, input logic [DQ_W-1:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check16
   // one request, expected data recorded on acceptance
   task automatic send(input logic w, input int b, input int r, input int c, input logic [DQ_W-1:0] d);
      int k;
      @(posedge clk);
      #1;
      req_valid = 1'b1;
      req_write = w;
      req_bank = BA_W'(b);
      req_row = ROW_W'(r);
      req_col = COL_W'(c);
      req_wdata = d;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (req_ready !== 1'b1 && k < 200);
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      if (k >= 200) failures++;
      if (w) exp_mem[b * 4096 + r * 256 + c] = d;
      else for (int i = 0; i < 4; i++) exp_q.push_back(exp_mem[b * 4096 + r * 256 + (c & 252) + ((c + i) & 3)]);
   endtask : send
   // pop n words from the read buffer and compare in order
   task automatic drain(input int n);
      int got;
      int k;
      got = 0;
      k = 0;
      rd_ready = 1'b1;
      while (got < n && k < 400) begin
         @(negedge clk);
         k++;
         if (rd_valid === 1'b1) begin
            check16(rd_data, exp_q.pop_front());
            got++;
         end
      end
      @(posedge clk);
      #1;
      rd_ready = 1'b0;
      if (k >= 400) failures++;
   endtask : drain
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish
   // watchdog
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      tally_and_finish();
   end
   // test sequence
   initial begin
      int k;
      repeat (20) @(posedge clk);
      #1;
      nrst = 1'b1;
      k = 0;
      while (init_done !== 1'b1 && k < 500) begin
         @(negedge clk);
         k++;
      end
      if (k >= 500) failures++;
      check16({4'h0, mode_word}, 16'h0222);
      $display("test init done");
      for (int i = 4; i < 8; i++) send(1'b1, 0, 1, i, 16'h1100 + 16'(i));
      for (int i = 0; i < 4; i++) send(1'b1, 1, 2, i, 16'h2200 + 16'(i));
      send(1'b0, 0, 1, 6, '0);
      drain(4);
      send(1'b1, 0, 1, 5, 16'h5a5a);
      send(1'b0, 0, 1, 4, '0);
      drain(4);
      $display("test burst order done");
      send(1'b0, 0, 1, 4, '0);
      send(1'b0, 1, 2, 0, '0);
      @(posedge clk);
      #1;
      req_valid = 1'b1;
      req_col = 8'h02;
      k = 0;
      repeat (16) begin
         @(negedge clk);
         if (req_ready === 1'b1) k++;
      end
      check16(16'(k), 16'h0000);
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      drain(8);
      send(1'b0, 1, 2, 2, '0);
      drain(4);
      $display("test back to back done");
      for (int i = 4; i < 8; i++) send(1'b1, 0, 3, i, 16'h3300 + 16'(i));
      send(1'b0, 0, 3, 4, '0);
      send(1'b0, 0, 1, 4, '0);
      drain(8);
      check16({12'h000, bank_open}, 16'h0003);
      $display("test row miss done");
      send(1'b0, 1, 2, 0, '0);
      fork
         send(1'b1, 1, 2, 1, 16'h7777);
         drain(4);
      join
      send(1'b0, 1, 2, 0, '0);
      drain(4);
      check16({15'h0000, inv_seen}, 16'h0000);
      $display("test turnaround done");
      tally_and_finish();
   end
endmodule : sdram_activate_read_path_tb
